// ==== inc/bit_op_pkg.sv ====
/*
 bit_op_pkg: opcode fields, widths, stack depth and reset values for the bit-operation execute block.
 assumes 14-bit instruction words and an 8-bit register file with 7-bit file addresses.
*/
package bit_op_pkg;
   localparam int INSTR_W   = 14;
   localparam int PC_W      = 11;
   localparam int FADDR_W   = 7;
   localparam int BIDX_W    = 3;
   localparam int DATA_W    = 8;
   localparam int STACK_D   = 8;
   localparam int SP_W      = 3;

   // field positions inside the instruction word
   localparam int OPC_HI    = 13;
   localparam int OPC_LO    = 10;
   localparam int BIDX_LO   = 7;
   localparam int FADDR_LO  = 0;

   localparam logic [3:0] OPC_CLR  = 4'h4;
   localparam logic [3:0] OPC_SET  = 4'h5;
   localparam logic [3:0] OPC_TSTC = 4'h6;

   localparam logic [PC_W-1:0]    PC_RESET  = 11'h000;
   localparam logic [PC_W-1:0]    IRQ_VEC   = 11'h004;
   localparam logic [SP_W-1:0]    SP_RESET  = 3'h0;
   localparam logic [DATA_W-1:0]  DATA_ZERO = 8'h00;

   typedef enum logic [1:0] {
      EX_RUN  = 2'b00,
      EX_SKIP = 2'b01,
      EX_IRQ  = 2'b10
   } exec_state_e;
endpackage

// ==== design/ret_stack.sv ====
/*
 ret_stack: circular hardware stack for return addresses.
 assumes push and pop never asserted together; overflow wraps and overwrites the oldest entry.
*/
`timescale 1ns/10ps
`default_nettype none
module ret_stack
   import bit_op_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        reset,
   input  wire logic                        push,
   input  wire logic                        pop,
   input  wire logic [bit_op_pkg::PC_W-1:0] push_data,
   output logic      [bit_op_pkg::PC_W-1:0] top_data
);
   logic [PC_W-1:0] mem [STACK_D];
   logic [SP_W-1:0] sp_reg;

   always_ff @(posedge mclk) begin
      if (reset) begin
         sp_reg <= SP_RESET;
      end else if (push) begin
         sp_reg <= sp_reg + 3'h1;
      end else if (pop) begin
         sp_reg <= sp_reg - 3'h1;
      end
   end

   // storage is not reset; only the pointer carries control state
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[sp_reg] <= push_data;
      end
   end

   assign top_data = mem[sp_reg - 3'h1];
endmodule
`default_nettype wire

// ==== design/bit_op_exec.sv ====
/*
 bit_op_exec: execute stage for the clear-bit, set-bit and test-bit-skip-if-clear instructions,
 with return-address save on interrupt entry.
 assumes the fetch path presents the prefetched word with instr_valid, and the register file answers
 reads combinationally in the same cycle; all on mclk.
*/
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE1 - on interrupt entry only the return program counter is pushed; working and status registers are untouched.
// RULE2 - word 01 00bb bfff ffff clears bit b of file register f, changes no flags, one word and one cycle.
// RULE3 - word 01 01bb bfff ffff sets bit b of file register f, changes no flags, one word and one cycle.
// RULE4 - word 01 10bb bfff ffff tests bit b of register f and skips the next instruction when it is zero.
// RULE5 - a taken skip discards the prefetched word and runs a no-operation, so the test takes two cycles.
// RULE6 - the file address is a seven-bit field 0 to 127 and the bit index a three-bit field 0 to 7.
// RULE7 - bit index zero is the least significant bit and modification is a read-modify-write of the register.
module bit_op_exec
   import bit_op_pkg::*;
(
   input  wire logic                            mclk,
   input  wire logic                            reset,
   input  wire logic [bit_op_pkg::INSTR_W-1:0]  instr,
   input  wire logic                            instr_valid,
   input  wire logic                            irq_req,
   input  wire logic                            ret_req,
   input  wire logic [bit_op_pkg::DATA_W-1:0]   rf_rdata,
   output logic      [bit_op_pkg::FADDR_W-1:0]  rf_addr,
   output logic      [bit_op_pkg::DATA_W-1:0]   rf_wdata,
   output logic                                 rf_we,
   output logic      [bit_op_pkg::PC_W-1:0]     pc,
   output logic                                 instr_accept,
   output logic                                 discard,
   output logic                                 irq_ack,
   output logic                                 bitop_done
);
   import bit_op_pkg::*;

   exec_state_e            state_reg;
   exec_state_e            state_next;
   logic [PC_W-1:0]        pc_reg;
   logic [PC_W-1:0]        pc_next;
   logic [PC_W-1:0]        stack_top;
   logic [3:0]             opc;
   logic [FADDR_W-1:0]     faddr;
   logic [BIDX_W-1:0]      bidx;
   logic                   is_clr;
   logic                   is_set;
   logic                   is_tst;
   logic                   dec_clr;
   logic                   dec_set;
   logic                   dec_tst;
   logic                   exec_ok;
   logic                   fwd_hit;
   logic [DATA_W-1:0]      rd_eff;
   logic                   run;
   logic                   take_irq;
   logic                   do_ret;
   logic                   skip_take;
   logic [DATA_W-1:0]      bit_mask;
   logic [FADDR_W-1:0]     rf_addr_reg;
   logic [DATA_W-1:0]      rf_wdata_reg;
   logic                   rf_we_reg;
   logic                   done_reg;
   logic                   ack_reg;

   function automatic logic [DATA_W-1:0] onehot(input logic [BIDX_W-1:0] b);
      onehot = DATA_W'(1) << b;   // see RULE7
   endfunction

   // see RULE6
   assign opc   = instr[OPC_HI:OPC_LO];
   assign faddr = instr[FADDR_LO +: FADDR_W];
   assign bidx  = instr[BIDX_LO +: BIDX_W];

   assign run      = (state_reg == EX_RUN);
   // interrupts wait for instruction boundaries, never mid-skip
   assign take_irq = run && irq_req;
   assign do_ret   = run && !irq_req && ret_req;
   assign exec_ok  = run && !irq_req && !ret_req && instr_valid;

   // one decode of the opcode field feeds the three execute strobes
   always_comb begin
      dec_clr = 1'b0;
      dec_set = 1'b0;
      dec_tst = 1'b0;
      case (opc)
         OPC_CLR: begin
            dec_clr = 1'b1;
         end
         OPC_SET: begin
            dec_set = 1'b1;
         end
         OPC_TSTC: begin
            dec_tst = 1'b1;
         end
         default: begin
            // other opcodes only step the program counter
            dec_clr = 1'b0;
         end
      endcase
   end

   assign is_clr   = exec_ok && dec_clr;   // see RULE2
   assign is_set   = exec_ok && dec_set;   // see RULE3
   assign is_tst   = exec_ok && dec_tst;   // see RULE4
   assign bit_mask = onehot(bidx);

   // a write still in flight to the same register is forwarded; without it two bit
   // operations back to back on one register would lose the first update
   assign fwd_hit  = rf_we_reg && (rf_addr_reg == faddr);
   assign rd_eff   = fwd_hit ? rf_wdata_reg : rf_rdata;   // see RULE7
   assign skip_take = is_tst && ((rd_eff & bit_mask) == DATA_ZERO);   // see RULE4

   // register file read address is combinational so the test and read-modify-write finish in one cycle
   assign rf_addr = faddr;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         EX_RUN: begin
            if (take_irq) begin
               state_next = EX_IRQ;
            end else if (skip_take) begin
               state_next = EX_SKIP;   // see RULE5
            end
         end
         EX_SKIP: begin
            state_next = EX_RUN;
         end
         EX_IRQ: begin
            state_next = EX_RUN;
         end
         default: begin
            state_next = EX_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= EX_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // program counter: skip cycle steps past the discarded word
   always_comb begin
      pc_next = pc_reg;
      if (take_irq) begin
         pc_next = IRQ_VEC;
      end else if (do_ret) begin
         pc_next = stack_top;
      end else if (state_reg == EX_SKIP) begin
         pc_next = pc_reg + 11'h1;   // see RULE5
      end else if (exec_ok) begin
         pc_next = pc_reg + 11'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         pc_reg <= PC_RESET;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // only the return address goes on the stack; no working or status copy exists here
   ret_stack u_ret_stack (
      .mclk      (mclk),
      .reset     (reset),
      .push      (take_irq),          // see RULE1
      .pop       (do_ret),
      .push_data (pc_reg),
      .top_data  (stack_top)
   );

   // read-modify-write, flags are never touched by these operations
   always_ff @(posedge mclk) begin
      if (reset) begin
         rf_we_reg   <= 1'b0;
         rf_addr_reg <= {FADDR_W{1'b0}};
      end else begin
         rf_we_reg   <= is_clr || is_set;
         rf_addr_reg <= faddr;
      end
   end

   // data holds its last value between writes, so only rf_we qualifies it
   always_ff @(posedge mclk) begin
      if (reset) begin
         rf_wdata_reg <= DATA_ZERO;
      end else if (is_clr) begin
         rf_wdata_reg <= rd_eff & ~bit_mask;   // see RULE2
      end else if (is_set) begin
         rf_wdata_reg <= rd_eff | bit_mask;    // see RULE3
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= is_clr || is_set || (is_tst && !skip_take) || (state_reg == EX_SKIP);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= take_irq;   // see RULE1
      end
   end

   // write port is registered; the far side keeps the write address one cycle itself
   assign rf_wdata     = rf_wdata_reg;
   assign rf_we        = rf_we_reg;
   assign pc           = pc_reg;
   assign instr_accept = run && !irq_req && !ret_req && instr_valid;
   assign discard      = (state_reg == EX_SKIP);   // see RULE5
   assign irq_ack      = ack_reg;
   assign bitop_done   = done_reg;
endmodule
`default_nettype wire

// ==== testbench/bit_op_chk.sv ====
/* bit_op_chk: port assertions for bit_op_exec.
 assumes one clock, mclk, with synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module bit_op_chk (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic [13:0] instr,
   input wire logic        instr_valid,
   input wire logic        irq_req,
   input wire logic        ret_req,
   input wire logic [7:0]  rf_rdata,
   input wire logic [6:0]  rf_addr,
   input wire logic [7:0]  rf_wdata,
   input wire logic        rf_we,
   input wire logic [10:0] pc,
   input wire logic        instr_accept,
   input wire logic        discard,
   input wire logic        irq_ack,
   input wire logic        bitop_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic [6:0] waddr_reg;
   // the register file takes a write one cycle late, so the pending data is forwarded to a read of that register
   always_ff @(posedge mclk) waddr_reg <= rf_addr;
   wire [3:0] opc = instr[13:10];
   wire [7:0] rd_eff = (rf_we && waddr_reg == rf_addr) ? rf_wdata : rf_rdata;
   wire       bsel = rd_eff[instr[9:7]];
   wire [7:0] msk = 8'h01 << instr[9:7];
   chk_clear_data:
   assert property (instr_accept && opc == 4'h4 |=> rf_we && rf_wdata == ($past(rd_eff) & ~$past(msk)))
      else $error("clear data wrong");
   chk_set_data:
   assert property (instr_accept && opc == 4'h5 |=> rf_we && rf_wdata == ($past(rd_eff) | $past(msk)))
      else $error("set data wrong");
   chk_skip_taken:
   assert property (instr_accept && opc == 4'h6 && !bsel |=> discard && !instr_accept && !rf_we)
      else $error("skip not taken");
   chk_skip_not:
   assert property (instr_accept && opc == 4'h6 && bsel |=> !discard && !rf_we)
      else $error("skip taken wrongly");
   chk_skip_two:
   assert property (discard |=> bitop_done && pc == $past(pc) + 11'h001)
      else $error("skip cycle wrong");
   chk_one_cycle:
   assert property (instr_accept && opc inside {4'h4, 4'h5} |=> bitop_done && pc == $past(pc) + 11'h001)
      else $error("not one cycle");
   chk_addr_field:
   assert property (instr_valid |-> rf_addr == instr[6:0])
      else $error("address field wrong");
   chk_irq_entry:
   assert property (irq_ack |-> pc == 11'h004 && !rf_we ##1 !irq_ack)
      else $error("interrupt entry wrong");
   cover property (discard);
   cover property (irq_ack);
   cover property (rf_we);
   cover property (instr_accept && rf_we && waddr_reg == rf_addr);
endmodule
bind bit_op_exec bit_op_chk i_bit_op_chk (.*);
`default_nettype wire

// ==== testbench/rf_model.sv ====
/* rf_model: 128 x 8 register file behind bit_op_exec.
 assumes a write lands at the edge that ends the rf_we cycle. */
`timescale 1ns/10ps
`default_nettype none
module rf_model (
   input wire logic       mclk,
   input wire logic [6:0] rf_addr,
   input wire logic [7:0] rf_wdata,
   input wire logic       rf_we,
   output logic     [7:0] rf_rdata
);
   logic [7:0] mem [128];
   logic [6:0] wr_addr_reg;
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 13);
   // write address trails the read address by one cycle
   always @(posedge mclk) wr_addr_reg <= rf_addr;
   always @(posedge mclk) if (rf_we) mem[wr_addr_reg] <= rf_wdata;
   assign rf_rdata = mem[rf_addr];
endmodule
`default_nettype wire

// ==== testbench/test_bit_op_instruction_exec.sv ====
/* test_bit_op_instruction_exec: scenarios for bit_op_exec.
 assumes rf_model as register file and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_bit_op_instruction_exec;
   import bit_op_pkg::*;
   logic        mclk = 0, reset = 1, instr_valid = 0, irq_req = 0, ret_req = 0;
   logic [13:0] instr = 14'h0000;
   logic [7:0]  rf_rdata, rf_wdata, old;
   logic [6:0]  rf_addr;
   logic [10:0] pc, p;
   logic        rf_we, instr_accept, discard, irq_ack, bitop_done, hit;
   int          mismatches = 0, comparisons = 0;
   bit_op_exec i_bit_op_exec (.*);
   rf_model i_rf_model (.*);
   initial forever #2 mclk = ~mclk;
   task automatic step(input logic [13:0] w, input logic v);
      @(posedge mclk);
      instr <= w;
      instr_valid <= v;
   endtask
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_modify;
      for (int b = 0; b < 8; b++) begin
         old = i_rf_model.mem[127];
         step({4'h4, 3'(b), 7'h7F}, 1'b1);
         step(14'h0000, 1'b0);
         step(14'h0000, 1'b0);
         @(negedge mclk);
         chk("clear", {3'h0, old & ~(8'h01 << b)}, {3'h0, i_rf_model.mem[127]});
         old = i_rf_model.mem[0];
         step({4'h5, 3'(b), 7'h00}, 1'b1);
         step(14'h0000, 1'b0);
         step(14'h0000, 1'b0);
         @(negedge mclk);
         chk("set", {3'h0, old | (8'h01 << b)}, {3'h0, i_rf_model.mem[0]});
      end
   endtask
   // the word after the test is executed or dropped, shown by register 9
   task automatic t_skip;
      for (int b = 0; b < 8; b++) begin
         hit = i_rf_model.mem[5][b];
         old = i_rf_model.mem[9];
         p = pc;
         step({4'h6, 3'(b), 7'h05}, 1'b1);
         step({4'h4, 3'(b), 7'h09}, 1'b1);
         @(negedge mclk);
         chk("discard", {10'h0, !hit}, {10'h0, discard});
         step(14'h0000, 1'b0);
         step(14'h0000, 1'b0);
         @(negedge mclk);
         chk("next", {3'h0, hit ? old & ~(8'h01 << b) : old}, {3'h0, i_rf_model.mem[9]});
         chk("pc", p + 11'h002, pc);
      end
   endtask
   task automatic t_irq;
      p = pc;
      @(posedge mclk);
      irq_req <= 1'b1;
      @(posedge mclk);
      irq_req <= 1'b0;
      @(negedge mclk);
      chk("irq_ack", 11'h001, {10'h0, irq_ack});
      chk("vector", IRQ_VEC, pc);
      @(posedge mclk);
      ret_req <= 1'b1;
      @(posedge mclk);
      ret_req <= 1'b0;
      @(negedge mclk);
      chk("return", p, pc);
   endtask
   // back-to-back modify and test of one register lean on the write still in flight
   task automatic t_chain;
      old = i_rf_model.mem[20];
      p = pc;
      step({4'h5, 3'h1, 7'h14}, 1'b1);
      step({4'h4, 3'h2, 7'h14}, 1'b1);
      step({4'h6, 3'h2, 7'h14}, 1'b1);
      step(14'h0000, 1'b0);
      @(negedge mclk);
      old = (old | 8'h02) & ~8'h04;
      chk("chain discard", {10'h0, !old[2]}, {10'h0, discard});
      step(14'h0000, 1'b0);
      @(negedge mclk);
      chk("chain data", {3'h0, old}, {3'h0, i_rf_model.mem[20]});
      chk("chain pc", p + 11'h004, pc);
      chk("chain done", 11'h001, {10'h0, bitop_done});
   endtask
   // reset in mid-run with a word pending, then an opcode outside the three
   task automatic t_reset;
      old = i_rf_model.mem[1];
      @(posedge mclk);
      reset <= 1'b1;
      instr <= {4'h5, 3'h1, 7'h01};
      instr_valid <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      instr <= {4'hC, 3'h1, 7'h01};
      @(negedge mclk);
      chk("reset pc", PC_RESET, pc);
      chk("reset we", 11'h000, {10'h0, rf_we});
      step(14'h0000, 1'b0);
      step(14'h0000, 1'b0);
      @(negedge mclk);
      chk("other pc", PC_RESET + 11'h001, pc);
      chk("other data", {3'h0, old}, {3'h0, i_rf_model.mem[1]});
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      chk("pc", PC_RESET, pc);
      t_modify;
      t_skip;
      t_irq;
      t_chain;
      t_reset;
      report_and_stop;
   end
   // whole run needs about 100 cycles
   initial begin
      repeat (1000) @(posedge mclk);
      mismatches++;
      report_and_stop;
   end
endmodule
`default_nettype wire
